// ---- shared/blit_pkg.sv ----
// constants and types for the bit-block transfer engine
package blit_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_FIRST  = 8'h00;
    localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_FW_MASK     = 8'h08;
    localparam logic [7:0] OFS_LW_MASK     = 8'h0C;
    localparam logic [7:0] OFS_PTR_A       = 8'h10;
    localparam logic [7:0] OFS_PTR_B       = 8'h14;
    localparam logic [7:0] OFS_PTR_C       = 8'h18;
    localparam logic [7:0] OFS_PTR_D       = 8'h1C;
    localparam logic [7:0] OFS_MOD_A       = 8'h20;
    localparam logic [7:0] OFS_MOD_B       = 8'h24;
    localparam logic [7:0] OFS_MOD_C       = 8'h28;
    localparam logic [7:0] OFS_MOD_D       = 8'h2C;
    localparam logic [7:0] OFS_DAT_A       = 8'h30;
    localparam logic [7:0] OFS_DAT_B       = 8'h34;
    localparam logic [7:0] OFS_DAT_C       = 8'h38;
    localparam logic [7:0] OFS_SIZE        = 8'h3C;
    localparam logic [7:0] OFS_READBACK    = 8'h40;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CF_USE_D     = 8;
    localparam int CF_USE_C     = 9;
    localparam int CF_USE_B     = 10;
    localparam int CF_USE_A     = 11;
    localparam int CF_ASH_LO    = 12;
    localparam int CS_BSH_LO    = 12;
    localparam int CS_DESCEND   = 1;
    localparam int CS_CARRY_IN  = 2;
    localparam int CS_FILL_INC  = 3;
    localparam int CS_FILL_EXC  = 4;
    localparam int RB_BUSY      = 14;
    localparam int RB_NONZERO   = 13;
    localparam int SZ_H_LO      = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_MASK = 16'hFFFF;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_PTR  = 32'h0000_0000;

    // ------------------------------------------------------------
    // step and engine states
    // ------------------------------------------------------------
    localparam logic [31:0] WORD_STEP = 32'h0000_0002;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH_A,
        ST_FETCH_B,
        ST_FETCH_C,
        ST_WRITE_D,
        ST_ADV
    } eng_state_t;

endpackage : blit_pkg

// ---- src/blit_descend_fill_flags.sv ----
// bit-block transfer engine: descending mode, area fill, status flags
// Operation
// - descend bit in second control selects direction
// - descending pointers step down two bytes
// - descending rows subtract modulo
// - descending shifts go left
// - first mask on first fetched, rightmost
// - fill after shift, mask, logic
// - inclusive bit 3, exclusive bit 4
// - inclusive fill keeps boundary bits
// - exclusive fill clears left boundary
// - fill state starts carry-in, toggles leftward
// - fill works on whole words
// - size write starts the blit
// - busy shown in readback while running
// - busy asserts on size write
// - finish raises blit finished flag
// - zero indication covers all logic results, taken before fill
// - zero readable in readback register
// - negative modulo adds normally
// - disabled channel feeds held data
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module blit_descend_fill_flags
    import blit_pkg::*;
#(
    parameter int HEIGHT_W = 10
)(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // chip memory dma
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [15:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    // status
    output logic             blit_finished_irq
);
    import blit_pkg::*;

    initial
    begin
        if (HEIGHT_W < 1 || HEIGHT_W > 10)
            $error("HEIGHT_W out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ph_act;
        logic        ph_wr;
        logic [7:0]  ph_addr;
        logic [15:0] ctrl_first;
        logic [15:0] ctrl_second;
        logic [15:0] fw_mask;
        logic [15:0] lw_mask;
        logic [3:0][31:0] ptr;
        logic [3:0][31:0] modv;
        logic [2:0][15:0] dat;
        logic [2:0][15:0] prev;
        logic [5:0]  width;
        logic [9:0]  height;
        logic [5:0]  col;
        logic [9:0]  row;
        logic        busy;
        logic        nonzero;
        logic        fill_st;
        logic        fin;
        eng_state_t  st;
        logic [31:0] rdata;
        logic        mreq;
        logic        mwe;
        logic [31:0] maddr;
        logic [15:0] mwdata;
    } regs_t;

    regs_t r_q;
    regs_t r_d;

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic        descend;
    logic [3:0]  ash;
    logic [3:0]  bsh;
    logic        first_col;
    logic        last_col;
    logic [15:0] a_mask;
    logic [15:0] a_msk;
    logic [15:0] a_out;
    logic [15:0] b_out;
    logic [15:0] logic_out;
    logic [15:0] fill_out;
    logic        fill_end;
    logic [16:0] fstate;
    logic        fill_en;
    logic [31:0] wr_data;

    assign descend   = r_q.ctrl_second[CS_DESCEND];
    assign ash       = r_q.ctrl_first[CF_ASH_LO +: 4];
    assign bsh       = r_q.ctrl_second[CS_BSH_LO +: 4];
    assign first_col = (r_q.col == 6'h00);
    assign last_col  = (r_q.col == r_q.width - 6'h01);
    assign fill_en   = r_q.ctrl_second[CS_FILL_INC]
                     | r_q.ctrl_second[CS_FILL_EXC];

    // first mask on first fetched word in either direction
    always_comb
    begin
        a_mask = 16'hFFFF;
        if (first_col)
            a_mask = a_mask & r_q.fw_mask;
        if (last_col)
            a_mask = a_mask & r_q.lw_mask;
    end

    assign a_msk = r_q.dat[0] & a_mask;

    // shifter: right ascending, left descending
    function automatic logic [15:0] shift_w(
        input logic [15:0] cur,
        input logic [15:0] prv,
        input logic [3:0]  sh,
        input logic        dsc
    );
        logic [31:0] cat;
        cat = 32'h0000_0000;
        if (dsc)
        begin
            cat = {cur, prv} << sh;
            shift_w = cat[31:16];
        end
        else
        begin
            cat = {prv, cur} >> sh;
            shift_w = cat[15:0];
        end
    endfunction : shift_w

    assign a_out = shift_w(a_msk, r_q.prev[0], ash, descend);
    assign b_out = shift_w(r_q.dat[1], r_q.prev[1], bsh, descend);

    // minterm: disabled channels still feed held data
    always_comb
    begin
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 16; i++)
        begin
            idx = {a_out[i], b_out[i], r_q.dat[2][i]};
            logic_out[i] = r_q.ctrl_first[idx];
        end
    end

    // fill after logic, whole word, right to left
    always_comb
    begin
        fstate[0] = r_q.fill_st;
        fill_out = logic_out;
        for (int i = 0; i < 16; i++)
        begin
            fstate[i+1] = fstate[i] ^ logic_out[i];
            if (fill_en)
            begin
                if (r_q.ctrl_second[CS_FILL_EXC])
                    fill_out[i] = fstate[i+1];
                else
                    fill_out[i] = fstate[i+1] | logic_out[i];
            end
        end
    end

    assign fill_end = fstate[16];
    assign wr_data  = {16'h0000, fill_out};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic        take;
    logic        wr_now;
    logic [31:0] step;

    assign take   = hsel & hready & htrans[1];
    assign wr_now = r_q.ph_act & r_q.ph_wr;
    assign step   = descend ? (32'h0 - WORD_STEP) : WORD_STEP;

    always_comb
    begin
        r_d = r_q;
        r_d.fin = 1'b0;
        r_d.ph_act = take;
        r_d.ph_wr = hwrite;
        r_d.ph_addr = haddr[7:0];
        if (take && !hwrite)
        begin
            r_d.rdata = 32'h0000_0000;
            case (haddr[7:0])
                OFS_CTRL_FIRST:  r_d.rdata[15:0] = r_q.ctrl_first;
                OFS_CTRL_SECOND: r_d.rdata[15:0] = r_q.ctrl_second;
                OFS_FW_MASK:     r_d.rdata[15:0] = r_q.fw_mask;
                OFS_LW_MASK:     r_d.rdata[15:0] = r_q.lw_mask;
                OFS_READBACK:
                begin
                    r_d.rdata[RB_BUSY] = r_q.busy;
                    r_d.rdata[RB_NONZERO] = r_q.nonzero;
                end
                default:         r_d.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_now)
        begin
            case (r_q.ph_addr)
                OFS_CTRL_FIRST:  r_d.ctrl_first = hwdata[15:0];
                OFS_CTRL_SECOND: r_d.ctrl_second = hwdata[15:0];
                OFS_FW_MASK:     r_d.fw_mask = hwdata[15:0];
                OFS_LW_MASK:     r_d.lw_mask = hwdata[15:0];
                OFS_PTR_A:       r_d.ptr[0] = hwdata;
                OFS_PTR_B:       r_d.ptr[1] = hwdata;
                OFS_PTR_C:       r_d.ptr[2] = hwdata;
                OFS_PTR_D:       r_d.ptr[3] = hwdata;
                OFS_MOD_A:       r_d.modv[0] = hwdata;
                OFS_MOD_B:       r_d.modv[1] = hwdata;
                OFS_MOD_C:       r_d.modv[2] = hwdata;
                OFS_MOD_D:       r_d.modv[3] = hwdata;
                OFS_DAT_A:       r_d.dat[0] = hwdata[15:0];
                OFS_DAT_B:       r_d.dat[1] = hwdata[15:0];
                OFS_DAT_C:       r_d.dat[2] = hwdata[15:0];
                OFS_SIZE:
                begin
                    r_d.width = (hwdata[5:0] == 6'h00)
                              ? 6'h3F : hwdata[5:0];
                    r_d.height = hwdata[SZ_H_LO +: 10];
                    r_d.col = 6'h00;
                    r_d.row = 10'h000;
                    r_d.busy = 1'b1;
                    r_d.nonzero = 1'b0;
                    r_d.fill_st = r_q.ctrl_second[CS_CARRY_IN];
                    r_d.prev = '0;
                    r_d.st = ST_FETCH_A;
                end
                default:         ;
            endcase
        end
        case (r_q.st)
            ST_IDLE: r_d.mreq = 1'b0;
            ST_FETCH_A, ST_FETCH_B, ST_FETCH_C:
            begin
                if (!r_q.mreq)
                begin
                    if (r_q.ctrl_first[CF_USE_A - int'(r_q.st) + 1])
                    begin
                        r_d.mreq = 1'b1;
                        r_d.mwe = 1'b0;
                        r_d.maddr = r_q.ptr[int'(r_q.st) - 1];
                    end
                    else
                        r_d.st = eng_state_t'(int'(r_q.st) + 1);
                end
                else if (mem_ack)
                begin
                    r_d.mreq = 1'b0;
                    r_d.dat[int'(r_q.st) - 1] = mem_rdata;
                    r_d.ptr[int'(r_q.st) - 1] =
                        r_q.ptr[int'(r_q.st) - 1] + step;
                    r_d.st = eng_state_t'(int'(r_q.st) + 1);
                end
            end
            ST_WRITE_D:
            begin
                if (!r_q.mreq)
                begin
                    if (|logic_out)
                        r_d.nonzero = 1'b1;
                    r_d.prev[0] = a_msk;
                    r_d.prev[1] = r_q.dat[1];
                    r_d.fill_st = fill_end;
                    if (r_q.ctrl_first[CF_USE_D])
                    begin
                        r_d.mreq = 1'b1;
                        r_d.mwe = 1'b1;
                        r_d.maddr = r_q.ptr[3];
                        r_d.mwdata = wr_data[15:0];
                    end
                    else
                        r_d.st = ST_ADV;
                end
                else if (mem_ack)
                begin
                    r_d.mreq = 1'b0;
                    r_d.ptr[3] = r_q.ptr[3] + step;
                    r_d.st = ST_ADV;
                end
            end
            ST_ADV:
            begin
                r_d.st = ST_FETCH_A;
                if (last_col)
                begin
                    r_d.col = 6'h00;
                    r_d.row = r_q.row + 10'h001;
                    r_d.fill_st = r_q.ctrl_second[CS_CARRY_IN];
                    for (int c = 0; c < 4; c++)
                        r_d.ptr[c] = descend
                            ? r_d.ptr[c] - r_q.modv[c]
                            : r_d.ptr[c] + r_q.modv[c];
                    if (r_q.row + 10'h001 >= r_q.height
                        && r_q.height != 10'h000)
                    begin
                        r_d.st = ST_IDLE;
                        r_d.busy = 1'b0;
                        r_d.fin = 1'b1;
                    end
                end
                else
                    r_d.col = r_q.col + 6'h01;
            end
            default: r_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_q <= '0;
            r_q.fw_mask <= RST_MASK;
            r_q.lw_mask <= RST_MASK;
            r_q.st <= ST_IDLE;
        end
        else if (ce)
            r_q <= r_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata            = r_q.rdata;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign mem_req           = r_q.mreq;
    assign mem_we            = r_q.mwe;
    assign mem_addr          = r_q.maddr;
    assign mem_wdata         = r_q.mwdata;
    assign blit_finished_irq = r_q.fin;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_busy_on_start: assert property (@(posedge clk) disable iff (srst)
        ce && wr_now && r_q.ph_addr == OFS_SIZE |=> r_q.busy)
        else $error("busy not set by size write");
    chk_fin_drops_busy: assert property (@(posedge clk) disable iff (srst)
        r_q.fin |-> !r_q.busy && $past(r_q.busy))
        else $error("finish without busy drop");
    chk_step_down: assert property (@(posedge clk) disable iff (srst)
        ce && descend && r_q.st == ST_WRITE_D && r_q.mreq && mem_ack
        && !wr_now |=> r_q.ptr[3] == $past(r_q.ptr[3]) - 32'h2)
        else $error("descending step wrong");
    chk_fill_inc: assert property (@(posedge clk) disable iff (srst)
        fill_en && !r_q.ctrl_second[CS_FILL_EXC]
        |-> (fill_out & logic_out) == logic_out)
        else $error("inclusive fill lost a boundary");
    chk_no_fill_pass: assert property (@(posedge clk) disable iff (srst)
        !fill_en |-> fill_out == logic_out)
        else $error("fill active while disabled");
    chk_zero_track: assert property (@(posedge clk) disable iff (srst)
        ce && r_q.st == ST_WRITE_D && !r_q.mreq && |logic_out
        |=> r_q.nonzero)
        else $error("nonzero not caught");
    chk_fill_parity: assert property (@(posedge clk) disable iff (srst)
        fill_end == (r_q.fill_st ^ (^logic_out)))
        else $error("fill state parity wrong");
    chk_mask_first: assert property (@(posedge clk) disable iff (srst)
        first_col |-> (a_msk & ~r_q.fw_mask) == 16'h0000)
        else $error("first mask not applied");
    cov_descend_blit: cover property (@(posedge clk) descend && r_q.fin);
    cov_fill_blit: cover property (@(posedge clk) fill_en && r_q.fin);
    cov_nonzero: cover property (@(posedge clk) r_q.fin && r_q.nonzero);

endmodule : blit_descend_fill_flags

`default_nettype wire

// ---- sim/blit_chip_mem.sv ----
// chip memory model answering the engine's word-wide dma requests
`timescale 1ns/10ps
`default_nettype none

module blit_chip_mem (
    // clock and answer delay in cycles
    input  wire logic        clk,
    input  wire logic [3:0]  lat,
    // dma request
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    // answer
    output var  logic        mem_ack,
    output var  logic [15:0] mem_rdata
);
    logic [15:0] mem [256];
    logic [31:0] wa [$];
    logic [15:0] wd [$];
    int          n_rd = 0;
    logic [3:0]  cnt = 4'h0;

    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 16'hA5A5;
    end

    // data line keeps toggling whenever no read answer stands
    always @(posedge clk)
    begin
        mem_rdata <= ~mem_rdata;
        if (mem_ack)
            mem_ack <= 1'b0;
        else if (mem_req && cnt < lat)
            cnt <= cnt + 4'h1;
        else if (mem_req)
        begin
            cnt     <= 4'h0;
            mem_ack <= 1'b1;
            if (mem_we)
            begin
                mem[mem_addr[8:1]] <= mem_wdata;
                wa.push_back(mem_addr);
                wd.push_back(mem_wdata);
            end
            else
            begin
                mem_rdata <= mem[mem_addr[8:1]];
                n_rd++;
            end
        end
    end
endmodule : blit_chip_mem

`default_nettype wire

// ---- sim/blit_descend_fill_flags_tb.sv ----
// testbench for the bit-block transfer engine
`timescale 1ns/10ps
`default_nettype none

module blit_descend_fill_flags_tb;
    import blit_pkg::*;

    typedef struct {
        logic [15:0] c0, c1;
        logic [31:0] msk;
        logic [15:0] pa, pd, ma, da, sz, ea, ed;
        logic [3:0]  wi, nr;
        logic        nz;
    } row_t;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic [31:0] hrdata, mem_addr, d;
    logic        hreadyout, hresp, mem_req, mem_we, mem_ack;
    logic        blit_finished_irq;
    logic [15:0] mem_wdata, mem_rdata;
    logic [3:0]  lat = 4'h6;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;

    // c0 c1 masks ptrA ptrD mod datA size addr data idx reads nonzero
    row_t rows [15] = '{
    '{16'h49F0, 16'h0000, 32'hFFFFFFFF, 16'h0100, 16'h0180, 16'h0000,
      16'h0000, 16'h0042, 16'h0182, 16'h4567, 4'h1, 4'h2, 1'b1},
    '{16'h49F0, 16'h0002, 32'hFFFFFFFF, 16'h0102, 16'h0182, 16'h0000,
      16'h0000, 16'h0042, 16'h0180, 16'h2345, 4'h1, 4'h2, 1'b1},
    '{16'h09F0, 16'h0002, 32'h00FFFF00, 16'h0102, 16'h0182, 16'h0000,
      16'h0000, 16'h0042, 16'h0182, 16'h0078, 4'h0, 4'h2, 1'b1},
    '{16'h09F0, 16'h0002, 32'h00FFFF00, 16'h0102, 16'h0182, 16'h0000,
      16'h0000, 16'h0042, 16'h0180, 16'h1200, 4'h1, 4'h2, 1'b1},
    '{16'h09F0, 16'h0000, 32'hFFFFFFFF, 16'h0100, 16'h0180, 16'h0004,
      16'h0000, 16'h0081, 16'h0186, 16'h0F0F, 4'h1, 4'h2, 1'b1},
    '{16'h09F0, 16'h0002, 32'hFFFFFFFF, 16'h010C, 16'h018C, 16'h0004,
      16'h0000, 16'h0081, 16'h0186, 16'h0F0F, 4'h1, 4'h2, 1'b1},
    '{16'h09F0, 16'h0000, 32'hFFFFFFFF, 16'h0106, 16'h0180, 16'hFFFE,
      16'h0000, 16'h0081, 16'h0180, 16'h0F0F, 4'h1, 4'h2, 1'b1},
    '{16'h09F0, 16'h000A, 32'hFFFFFFFF, 16'h0104, 16'h0184, 16'h0000,
      16'h0000, 16'h0041, 16'h0184, 16'h3C18, 4'h0, 4'h1, 1'b1},
    '{16'h09F0, 16'h0012, 32'hFFFFFFFF, 16'h0104, 16'h0184, 16'h0000,
      16'h0000, 16'h0041, 16'h0184, 16'h1C08, 4'h0, 4'h1, 1'b1},
    '{16'h09F0, 16'h000E, 32'hFFFFFFFF, 16'h0104, 16'h0184, 16'h0000,
      16'h0000, 16'h0041, 16'h0184, 16'hE7FF, 4'h0, 4'h1, 1'b1},
    '{16'h09F0, 16'h0016, 32'hFFFFFFFF, 16'h0104, 16'h0184, 16'h0000,
      16'h0000, 16'h0041, 16'h0184, 16'hE3F7, 4'h0, 4'h1, 1'b1},
    '{16'h01F0, 16'h0000, 32'hFFFFFFFF, 16'h0000, 16'h0180, 16'h0000,
      16'h00FF, 16'h0041, 16'h0180, 16'h00FF, 4'h0, 4'h0, 1'b1},
    '{16'h07CA, 16'h0000, 32'h0FF0FFFF, 16'h0000, 16'h0180, 16'h0000,
      16'hFFFF, 16'h0041, 16'h0180, 16'h5AA5, 4'h0, 4'h2, 1'b1},
    '{16'h01F0, 16'h0000, 32'hFFFFFFFF, 16'h0000, 16'h0180, 16'h0000,
      16'h0000, 16'h0041, 16'h0180, 16'h0000, 4'h0, 4'h0, 1'b0},
    '{16'h08F0, 16'h0000, 32'hFFFFFFFF, 16'h0100, 16'h0180, 16'h0000,
      16'h0000, 16'h0041, 16'h0000, 16'h0000, 4'hF, 4'h1, 1'b1}
    };

    assign hready = hreadyout;

    always #12.5 clk = ~clk;

    blit_descend_fill_flags blit_descend_fill_flags_i (
        .clk, .srst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .blit_finished_irq
    );

    blit_chip_mem blit_chip_mem_i (
        .clk, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata
    );

    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [15:0] v);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        // modulo registers take a signed word
        hwdata <= {(a >= OFS_MOD_A && a <= OFS_MOD_D) ? {16{v[15]}}
                                                     : 16'h0000, v};
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata;
    endtask : ahb

    task automatic run(input row_t r);
        int k;
        ahb(1'b1, OFS_CTRL_FIRST, r.c0);
        ahb(1'b1, OFS_CTRL_SECOND, r.c1);
        ahb(1'b1, OFS_FW_MASK, r.msk[31:16]);
        ahb(1'b1, OFS_LW_MASK, r.msk[15:0]);
        ahb(1'b1, OFS_PTR_A, r.pa);
        ahb(1'b1, OFS_PTR_B, 16'h0140);
        ahb(1'b1, OFS_PTR_C, 16'h0160);
        ahb(1'b1, OFS_PTR_D, r.pd);
        ahb(1'b1, OFS_MOD_A, r.ma);
        ahb(1'b1, OFS_MOD_D, r.ma);
        ahb(1'b1, OFS_DAT_A, r.da);
        blit_chip_mem_i.wa.delete();
        blit_chip_mem_i.wd.delete();
        blit_chip_mem_i.n_rd = 0;
        ahb(1'b1, OFS_SIZE, r.sz);
        ahb(1'b0, OFS_READBACK, 16'h0);
        cmp("busy", 32'h1 << RB_BUSY, d & (32'h1 << RB_BUSY));
        k = 0;
        while (blit_finished_irq !== 1'b1 && k < 4000)
        begin
            @(posedge clk);
            k++;
        end
        cmp("finish", 32'h1, {31'h0, blit_finished_irq});
        ahb(1'b0, OFS_READBACK, 16'h0);
        cmp("flags", {31'h0, r.nz} << RB_NONZERO, d);
        cmp("reads", {28'h0, r.nr}, 32'(blit_chip_mem_i.n_rd));
        if (r.wi != 4'hF)
        begin
            cmp("waddr", {16'h0, r.ea}, blit_chip_mem_i.wa[r.wi]);
            cmp("wdata", {16'h0, r.ed},
                {16'h0, blit_chip_mem_i.wd[r.wi]});
        end
    endtask : run

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        blit_chip_mem_i.mem[8'h80] = 16'h1234;
        blit_chip_mem_i.mem[8'h81] = 16'h5678;
        blit_chip_mem_i.mem[8'h82] = 16'h2418;
        blit_chip_mem_i.mem[8'h83] = 16'h0F0F;
        blit_chip_mem_i.mem[8'h86] = 16'h3C3C;
        blit_chip_mem_i.mem[8'hA0] = 16'hAAAA;
        blit_chip_mem_i.mem[8'hB0] = 16'h5555;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        ahb(1'b0, OFS_READBACK, 16'h0);
        cmp("rb_reset", 32'h0, d);
        cmp("hresp", 32'h0, {31'h0, hresp});
        ahb(1'b1, 8'h44, 16'hFFFF);
        ahb(1'b0, 8'h44, 16'h0);
        cmp("unmapped", 32'h0, d);
        for (int i = 0; i < 15; i++)
            run(rows[i]);
        // prompt memory, back to back blits
        lat <= 4'h0;
        run(rows[0]);
        run(rows[9]);
        // endless blit aborted by reset
        ahb(1'b1, OFS_CTRL_FIRST, 16'h01F0);
        ahb(1'b1, OFS_SIZE, 16'h0001);
        ahb(1'b0, OFS_READBACK, 16'h0);
        cmp("busy_run", 32'h1 << RB_BUSY, d & (32'h1 << RB_BUSY));
        // frozen engine keeps its request where it is
        ce <= 1'b0;
        @(posedge clk);
        d = mem_addr;
        repeat (8) @(posedge clk);
        cmp("ce_hold", d, mem_addr);
        ce <= 1'b1;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        cmp("req_reset", 32'h0, {31'h0, mem_req});
        ahb(1'b0, OFS_READBACK, 16'h0);
        cmp("rb_abort", 32'h0, d);
        summarize();
    end
endmodule : blit_descend_fill_flags_tb

`default_nettype wire
